// *** dv/rls_host_model.sv ***
`timescale 1ns/1ns
// Host side of the register port; holds each strobe one cycle and samples read data after it.
module rls_host_model
  import rls_pkg::*;
(
  input wire logic core_clk,
  input wire logic [7:0] rdData,
  output rls_bus_type bus
);
  initial bus = '0;
  task automatic wr(input logic [7:0] a, input logic [7:0] v);
    @(posedge core_clk);
    bus.addr <= a;
    bus.wrData <= v;
    bus.wrStb <= 1'b1;
    @(posedge core_clk);
    bus <= '0;
  endtask
  task automatic rd(input logic [7:0] a, output logic [7:0] v);
    @(posedge core_clk);
    bus.addr <= a;
    bus.rdStb <= 1'b1;
    @(posedge core_clk);
    bus <= '0;
    #1;
    v = rdData;
  endtask
endmodule // rls_host_model

// *** dv/tb_rls_rx_status.sv ***
`timescale 1ns/1ns
module tb_rls_rx_status
  import rls_pkg::*;
();
  logic core_clk = 1'b0;
  logic sys_rst = 1'b1;
  rls_bus_type bus;
  rls_evt_type evt;
  rls_evt_type p;
  logic [7:0] rdData;
  logic [7:0] d;
  logic interruptOut_n;
  logic spareRestart;
  logic [15:0] spareMasked;
  int errors = 0;
  int num_checks = 0;
  logic [7:0] rstRegs [6] = '{8'h94, 8'h96, 8'h9c, 8'h9d, 8'h9f, 8'ha0};
  always #2 core_clk = ~core_clk;
  // A short free-running multiframe period keeps the run brief.
  rls_rx_status #(.MF_FREE_CYCLES(20)) dut_u (.core_clk(core_clk), .sys_rst(sys_rst),
    .bus(bus), .evt(evt), .rdData(rdData), .interruptOut_n(interruptOut_n),
    .spareRestart(spareRestart), .spareMasked(spareMasked));
  rls_host_model host_u (.core_clk(core_clk), .rdData(rdData), .bus(bus));
  task automatic cmp(input logic [15:0] got, input logic [15:0] exp);
    num_checks++;
    if (got !== exp) begin
      errors++;
      $display("[FAIL] %0t got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic rdChk(input logic [7:0] a, input logic [7:0] e);
    host_u.rd(a, d);
    cmp({8'h00, d}, {8'h00, e});
  endtask
  task automatic irqChk(input logic e);
    cmp({15'h0000, interruptOut_n}, {15'h0000, e});
  endtask
  task automatic fire(input rls_evt_type m);
    @(posedge core_clk);
    evt <= evt | m;
    @(posedge core_clk);
    evt <= evt & ~m;
  endtask
  task automatic cyc(input int n);
    repeat (n) @(posedge core_clk);
    #1;
  endtask
  task automatic end_sim;
    $display("checks %0d errors %0d", num_checks, errors);
    if (errors == 0 && num_checks > 0) begin
      $display("Test passed");
    end else begin
      $display("Test failed");
    end
    $finish;
  endtask
  initial begin
    #200000;
    errors++;
    end_sim();
  end
  initial begin
    evt = '0;
    repeat (2) @(posedge core_clk);
    sys_rst <= 1'b0;
    cyc(1);
    irqChk(1'b1);
    foreach (rstRegs[i]) rdChk(rstRegs[i], 8'h00);
    host_u.wr(8'ha0, 8'ha5);
    rdChk(8'ha0, 8'ha5);
    @(posedge core_clk);
    evt.latchedStatusOne <= 8'h04;
    cyc(3);
    rdChk(8'h9f, 8'h01);
    irqChk(1'b0);
    @(posedge core_clk);
    evt.latchedStatusOne <= 8'h02;
    cyc(3);
    rdChk(8'h9f, 8'h00);
    irqChk(1'b1);
    evt.spareLen <= 5'h03;
    host_u.wr(8'h9c, 8'hff);
    #1;
    cmp({15'h0000, spareRestart}, 16'h0001);
    host_u.wr(8'h9d, 8'hff);
    #1;
    cmp({15'h0000, spareRestart}, 16'h0000);
    cyc(2);
    cmp(spareMasked, 16'he000);
    evt.spareLen <= 5'h0c;
    cyc(3);
    cmp(spareMasked, 16'hfff0);
    p = '0;
    p.ovrAbandon = 1'b1;
    p.openingByteNext = 1'b1;
    p.pktEnd = 1'b1;
    fire(p);
    cyc(1);
    rdChk(8'h94, 8'h38);
    p = '0;
    p.pktStart = 1'b1;
    fork
      host_u.rd(8'h94, d);
      fire(p);
    join
    cmp({8'h00, d}, 16'h0000);
    rdChk(8'h94, 8'h04);
    rdChk(8'h94, 8'h00);
    host_u.wr(8'had, 8'h0a);
    evt.fifoLevel <= 7'h05;
    cyc(2);
    rdChk(8'h94, 8'h01);
    evt.fifoLevel <= 7'h0b;
    cyc(2);
    rdChk(8'h94, 8'h02);
    rdChk(8'h94, 8'h00);
    host_u.wr(8'ha4, 8'h04);
    p = '0;
    p.pktEnd = 1'b1;
    fire(p);
    cyc(4);
    irqChk(1'b1);
    p = '0;
    p.pktStart = 1'b1;
    fire(p);
    cyc(4);
    irqChk(1'b0);
    rdChk(8'h9f, 8'h10);
    rdChk(8'h94, 8'h0c);
    cyc(3);
    rdChk(8'h9f, 8'h00);
    irqChk(1'b1);
    host_u.wr(8'ha8, 8'h01);
    host_u.wr(8'ha3, 8'h08);
    p = '0;
    p.sigChange = 32'h8000_0003;
    fire(p);
    cyc(4);
    irqChk(1'b0);
    rdChk(8'h98, 8'h03);
    rdChk(8'h9b, 8'h00);
    rdChk(8'h93, 8'h08);
    p.sigChange = 32'h0000_0002;
    fire(p);
    cyc(4);
    irqChk(1'b1);
    rdChk(8'h98, 8'h02);
    rdChk(8'h93, 8'h00);
    cyc(25);
    rdChk(8'h93, 8'h00);
    p = '0;
    p.t1MfBoundary = 1'b1;
    fire(p);
    rdChk(8'h93, 8'h01);
    evt.esfMode <= 1'b1;
    evt.raiCond <= 1'b1;
    evt.aisCond <= 1'b1;
    evt.slcReady <= 1'b1;
    p = '0;
    p.raiCi = 1'b1;
    p.aisCi = 1'b1;
    p.slcAlign = 1'b1;
    p.fdlFull = 1'b1;
    p.bocDetect = 1'b1;
    p.bocClear = 1'b1;
    fire(p);
    rdChk(8'h96, 8'h3f);
    evt.raiCond <= 1'b0;
    evt.aisCond <= 1'b0;
    fire(p);
    rdChk(8'h96, 8'h0f);
    // Realign the free-running multiframe counter so the E1 checks land at known cycles.
    p = '0;
    p.e1CasBoundary = 1'b1;
    fire(p);
    #1;
    evt.e1Mode <= 1'b1;
    rdChk(8'h93, 8'h00);
    cyc(25);
    rdChk(8'h93, 8'h01);
    evt.casEnabled <= 1'b1;
    fire(p);
    rdChk(8'h93, 8'h01);
    cyc(25);
    rdChk(8'h93, 8'h00);
    host_u.wr(8'hac, 8'h1f);
    p = '0;
    p.saStrobe = 1'b1;
    fire(p);
    rdChk(8'h96, 8'h00);
    p.saBits = 5'h01;
    p.sa6Codeword = 1'b1;
    fire(p);
    rdChk(8'h96, 8'h03);
    p = '0;
    p.sigChange = 32'h8000_0000;
    fire(p);
    rdChk(8'h9b, 8'h80);
    end_sim();
  end
endmodule // tb_rls_rx_status

// *** shared/rls_cfg.svh ***
`ifndef RLS_CFG_SVH
`define RLS_CFG_SVH
`define RLS_OFF_LS4 8'h93
`define RLS_OFF_LS5 8'h94
`define RLS_OFF_LS7 8'h96
`define RLS_OFF_SS1 8'h98
`define RLS_OFF_SS2 8'h99
`define RLS_OFF_SS3 8'h9a
`define RLS_OFF_SS4 8'h9b
`define RLS_OFF_SCD1 8'h9c
`define RLS_OFF_SCD2 8'h9d
`define RLS_OFF_SUM 8'h9f
`define RLS_OFF_IM1 8'ha0
`define RLS_OFF_IM4 8'ha3
`define RLS_OFF_IM5 8'ha4
`define RLS_OFF_IM7 8'ha6
`define RLS_OFF_SCE1 8'ha8
`define RLS_OFF_SCE2 8'ha9
`define RLS_OFF_SCE3 8'haa
`define RLS_OFF_SCE4 8'hab
`define RLS_OFF_SAIM 8'hac
`define RLS_OFF_HFC 8'had
`define RLS_RST_BYTE 8'h00
`define RLS_B4_MF 0
`define RLS_B4_SCOS 3
`define RLS_B5_OVR 5
`define RLS_B5_OBT 4
`define RLS_B5_PE 3
`define RLS_B5_PS 2
`define RLS_B5_HWM 1
`define RLS_B5_NE 0
`define RLS_B7_RAI 5
`define RLS_B7_AIS 4
`define RLS_B7_SLC 3
`define RLS_B7_FDL 2
`define RLS_B7_BC 1
`define RLS_B7_BD 0
`define RLS_B7_SA6 1
`define RLS_B7_SAX 0
`define RLS_BS_LS1 0
`define RLS_BS_LS4 3
`define RLS_BS_LS5 4
`define RLS_BS_LS7 6
`define RLS_CLK_MHZ 250
`define RLS_E1_MF_TIME_US 2000
`define RLS_MF_CNT_W 20
`endif

// *** shared/rls_pkg.sv ***
`include "rls_cfg.svh"
package rls_pkg;
  typedef struct packed {
    logic [7:0] addr;
    logic [7:0] wrData;
    logic wrStb;
    logic rdStb;
  } rls_bus_type;
  typedef struct packed {
    logic e1Mode;
    logic esfMode;
    logic casEnabled;
    logic t1MfBoundary;
    logic e1CasBoundary;
    logic [6:0] fifoLevel;
    logic ovrAbandon;
    logic openingByteNext;
    logic pktEnd;
    logic pktStart;
    logic raiCi;
    logic raiCond;
    logic aisCi;
    logic aisCond;
    logic slcAlign;
    logic slcReady;
    logic fdlFull;
    logic bocDetect;
    logic bocClear;
    logic sa6Codeword;
    logic saStrobe;
    logic [4:0] saBits;
    logic [31:0] sigChange;
    logic [7:0] latchedStatusOne;
    logic [4:0] spareLen;
  } rls_evt_type;
  typedef struct packed {
    logic [7:0] ls4;
    logic [7:0] ls5;
    logic [7:0] ls7t;
    logic [7:0] ls7e;
    logic [31:0] sigSticky;
    logic [7:0] scd1;
    logic [7:0] scd2;
    logic [7:0] im1;
    logic [7:0] im4;
    logic [7:0] im5;
    logic [7:0] im7;
    logic [31:0] sigEnable;
    logic [4:0] saMask;
    logic [6:0] watermark;
    logic prevAbove;
    logic prevNonEmpty;
    logic [4:0] saPrev;
    logic saPrevValid;
    logic [`RLS_MF_CNT_W-1:0] mfCnt;
    logic [7:0] rdData;
    logic spareRestart;
    logic [15:0] spareMasked;
    logic [7:0] summary;
    logic irqN;
  } rls_state_type;
endpackage

// *** verilog/rls_rx_status.sv ***
`timescale 1ns/1ns
`include "rls_cfg.svh"
// Overview of operation
// - T1 multiframe event on D4/ESF boundary.
// - E1 event every 2ms, CAS or free-running.
// - Latch overrun when HDLC abandons on full FIFO.
// - Latch flag when next FIFO byte opens message.
// - Latch packet end or fault; read clears.
// - Latch packet start on opening byte; read clears.
// - Latch rising edge of above-watermark condition.
// - Latch FIFO empty to not-empty transition.
// - RAI-CI latches in ESF during remote alarm.
// - AIS-CI latches only during AIS condition.
// - SLC-96 alignment with data ready latches flag.
// - Latch flag when FDL holding byte fills.
// - Latch BOC detect and BOC clear events.
// - E1 Sa6 codeword found latches flag.
// - E1 enabled Sa bit change latches flag.
// - Per-channel signaling change bits, held until read.
// - Enabled changes raise event; unmasked drives interrupt.
// - Writing first spare register restarts integration.
// - Spare pattern MSB first; unused bits ignored.
// - Summary register has one bit per status register.
// - Summary clears when serviced; masked bits excluded.
// - Mask bit one enables, zero blocks; reset zero.
module rls_rx_status
  import rls_pkg::*;
#(
  parameter int unsigned MF_FREE_CYCLES = `RLS_E1_MF_TIME_US * `RLS_CLK_MHZ
) (
  input wire logic core_clk,
  input wire logic sys_rst,
  input wire rls_bus_type bus,
  input wire rls_evt_type evt,
  output logic [7:0] rdData,
  output logic interruptOut_n,
  output logic spareRestart,
  output logic [15:0] spareMasked
);

  rls_state_type st;
  rls_state_type stNext;

  function automatic logic hit(input rls_bus_type b, input logic [7:0] off, input logic rd);
    hit = (rd ? b.rdStb : b.wrStb) && (b.addr == off);
  endfunction

  // Keeps the leading spareLen bits of the 16-bit pattern, first bit at the top.
  function automatic logic [15:0] spareMask(input logic [15:0] pat, input logic [4:0] len);
    logic [15:0] m;
    m = 16'h0000;
    for (int i = 0; i < 16; i++) begin
      m[15 - i] = (5'(i) < len) ? pat[15 - i] : 1'b0;
    end
    spareMask = m;
  endfunction

  logic [7:0] set4;
  logic [7:0] set5;
  logic [7:0] set7t;
  logic [7:0] set7e;
  logic [31:0] sigMaskMode;
  logic aboveNow;
  logic nonEmptyNow;
  logic mfFreeEnd;
  logic [7:0] ls7Sel;

  always_comb begin
    stNext = st;
    set4 = 8'h00;
    set5 = 8'h00;
    set7t = 8'h00;
    set7e = 8'h00;
    // Channels 25 to 32 only exist on an E1 line.
    sigMaskMode = evt.e1Mode ? 32'hffffffff : 32'h00ffffff;
    aboveNow = evt.fifoLevel > st.watermark;
    nonEmptyNow = evt.fifoLevel != 7'h00;
    mfFreeEnd = st.mfCnt == `RLS_MF_CNT_W'(MF_FREE_CYCLES - 1);
    ls7Sel = evt.e1Mode ? st.ls7e : st.ls7t;

    // Free-running counter realigns on every CAS boundary so the fallback keeps its phase.
    if (mfFreeEnd || evt.e1CasBoundary) begin
      stNext.mfCnt = '0;
    end else begin
      stNext.mfCnt = `RLS_MF_CNT_W'(st.mfCnt + 1'b1);
    end
    if (!evt.e1Mode) begin
      set4[`RLS_B4_MF] = evt.t1MfBoundary;
    end else if (evt.casEnabled) begin
      set4[`RLS_B4_MF] = evt.e1CasBoundary;
    end else begin
      set4[`RLS_B4_MF] = mfFreeEnd;
    end
    set4[`RLS_B4_SCOS] = |(evt.sigChange & st.sigEnable & sigMaskMode);

    set5[`RLS_B5_OVR] = evt.ovrAbandon;
    set5[`RLS_B5_OBT] = evt.openingByteNext;
    set5[`RLS_B5_PE] = evt.pktEnd;
    set5[`RLS_B5_PS] = evt.pktStart;
    set5[`RLS_B5_HWM] = aboveNow && !st.prevAbove;
    set5[`RLS_B5_NE] = nonEmptyNow && !st.prevNonEmpty;
    stNext.prevAbove = aboveNow;
    stNext.prevNonEmpty = nonEmptyNow;

    if (!evt.e1Mode) begin
      set7t[`RLS_B7_RAI] = evt.raiCi && evt.esfMode && evt.raiCond;
      set7t[`RLS_B7_AIS] = evt.aisCi && evt.aisCond;
      set7t[`RLS_B7_SLC] = evt.slcAlign && evt.slcReady;
      set7t[`RLS_B7_FDL] = evt.fdlFull;
      set7t[`RLS_B7_BC] = evt.bocClear;
      set7t[`RLS_B7_BD] = evt.bocDetect;
    end else begin
      set7e[`RLS_B7_SA6] = evt.sa6Codeword;
      // The first sample after reset only primes the history, so no false change is seen.
      if (evt.saStrobe) begin
        set7e[`RLS_B7_SAX] = st.saPrevValid && |((evt.saBits ^ st.saPrev) & st.saMask);
      end
    end
    if (evt.saStrobe) begin
      stNext.saPrev = evt.saBits;
      stNext.saPrevValid = 1'b1;
    end

    // A set in the same cycle as the clearing read wins, so no event is lost.
    stNext.ls4 = (st.ls4 & ~{8{hit(bus, `RLS_OFF_LS4, 1'b1)}}) | set4;
    stNext.ls5 = (st.ls5 & ~{8{hit(bus, `RLS_OFF_LS5, 1'b1)}}) | set5;
    stNext.ls7t = (st.ls7t & ~{8{hit(bus, `RLS_OFF_LS7, 1'b1) && !evt.e1Mode}}) | set7t;
    stNext.ls7e = (st.ls7e & ~{8{hit(bus, `RLS_OFF_LS7, 1'b1) && evt.e1Mode}}) | set7e;
    stNext.sigSticky[7:0] = (st.sigSticky[7:0] & ~{8{hit(bus, `RLS_OFF_SS1, 1'b1)}})
      | evt.sigChange[7:0];
    stNext.sigSticky[15:8] = (st.sigSticky[15:8] & ~{8{hit(bus, `RLS_OFF_SS2, 1'b1)}})
      | evt.sigChange[15:8];
    stNext.sigSticky[23:16] = (st.sigSticky[23:16] & ~{8{hit(bus, `RLS_OFF_SS3, 1'b1)}})
      | evt.sigChange[23:16];
    stNext.sigSticky[31:24] = (st.sigSticky[31:24] & ~{8{hit(bus, `RLS_OFF_SS4, 1'b1)}})
      | (evt.sigChange[31:24] & sigMaskMode[31:24]);

    stNext.spareRestart = hit(bus, `RLS_OFF_SCD1, 1'b0);
    if (hit(bus, `RLS_OFF_SCD1, 1'b0)) stNext.scd1 = bus.wrData;
    if (hit(bus, `RLS_OFF_SCD2, 1'b0)) stNext.scd2 = bus.wrData;
    if (hit(bus, `RLS_OFF_IM1, 1'b0)) stNext.im1 = bus.wrData;
    if (hit(bus, `RLS_OFF_IM4, 1'b0)) stNext.im4 = bus.wrData;
    if (hit(bus, `RLS_OFF_IM5, 1'b0)) stNext.im5 = bus.wrData;
    if (hit(bus, `RLS_OFF_IM7, 1'b0)) stNext.im7 = bus.wrData;
    if (hit(bus, `RLS_OFF_SCE1, 1'b0)) stNext.sigEnable[7:0] = bus.wrData;
    if (hit(bus, `RLS_OFF_SCE2, 1'b0)) stNext.sigEnable[15:8] = bus.wrData;
    if (hit(bus, `RLS_OFF_SCE3, 1'b0)) stNext.sigEnable[23:16] = bus.wrData;
    if (hit(bus, `RLS_OFF_SCE4, 1'b0)) stNext.sigEnable[31:24] = bus.wrData;
    if (hit(bus, `RLS_OFF_SAIM, 1'b0)) stNext.saMask = bus.wrData[4:0];
    if (hit(bus, `RLS_OFF_HFC, 1'b0)) stNext.watermark = bus.wrData[6:0];
    stNext.spareMasked = spareMask({st.scd1, st.scd2}, evt.spareLen);

    // Summary follows the latched bits one cycle later; slots 1, 2, 5 and 7 read zero.
    stNext.summary = 8'h00;
    stNext.summary[`RLS_BS_LS1] = |(evt.latchedStatusOne & st.im1);
    stNext.summary[`RLS_BS_LS4] = |(st.ls4 & st.im4);
    stNext.summary[`RLS_BS_LS5] = |(st.ls5 & st.im5);
    stNext.summary[`RLS_BS_LS7] = |(ls7Sel & st.im7);
    stNext.irqN = ~|stNext.summary;

    stNext.rdData = 8'h00;
    if (bus.rdStb) begin
      unique case (bus.addr)
        `RLS_OFF_LS4: stNext.rdData = st.ls4;
        `RLS_OFF_LS5: stNext.rdData = st.ls5;
        `RLS_OFF_LS7: stNext.rdData = ls7Sel;
        `RLS_OFF_SS1: stNext.rdData = st.sigSticky[7:0];
        `RLS_OFF_SS2: stNext.rdData = st.sigSticky[15:8];
        `RLS_OFF_SS3: stNext.rdData = st.sigSticky[23:16];
        `RLS_OFF_SS4: stNext.rdData = st.sigSticky[31:24];
        `RLS_OFF_SCD1: stNext.rdData = st.scd1;
        `RLS_OFF_SCD2: stNext.rdData = st.scd2;
        `RLS_OFF_SUM: stNext.rdData = st.summary;
        `RLS_OFF_IM1: stNext.rdData = st.im1;
        `RLS_OFF_IM4: stNext.rdData = st.im4;
        `RLS_OFF_IM5: stNext.rdData = st.im5;
        `RLS_OFF_IM7: stNext.rdData = st.im7;
        `RLS_OFF_SCE1: stNext.rdData = st.sigEnable[7:0];
        `RLS_OFF_SCE2: stNext.rdData = st.sigEnable[15:8];
        `RLS_OFF_SCE3: stNext.rdData = st.sigEnable[23:16];
        `RLS_OFF_SCE4: stNext.rdData = st.sigEnable[31:24];
        `RLS_OFF_SAIM: stNext.rdData = {3'h0, st.saMask};
        `RLS_OFF_HFC: stNext.rdData = {1'b0, st.watermark};
        default: stNext.rdData = 8'h00;
      endcase
    end
  end

  always_ff @(posedge core_clk or posedge sys_rst) begin
    if (sys_rst) begin
      st <= '0;
      st.irqN <= 1'b1;
      st.im1 <= `RLS_RST_BYTE;
      st.im4 <= `RLS_RST_BYTE;
      st.im5 <= `RLS_RST_BYTE;
      st.im7 <= `RLS_RST_BYTE;
    end else begin
      st <= stNext;
    end
  end

  assign rdData = st.rdData;
  assign interruptOut_n = st.irqN;
  assign spareRestart = st.spareRestart;
  assign spareMasked = st.spareMasked;

  property p_mf_t1;
    @(posedge core_clk) disable iff (sys_rst)
      (!evt.e1Mode && evt.t1MfBoundary) |=> st.ls4[`RLS_B4_MF];
  endproperty
  a_mf_t1: assert property (p_mf_t1) else $error("T1 multiframe event missed.");

  property p_mf_e1;
    @(posedge core_clk) disable iff (sys_rst)
      (evt.e1Mode && evt.casEnabled && evt.e1CasBoundary) |=> st.ls4[`RLS_B4_MF];
  endproperty
  a_mf_e1: assert property (p_mf_e1) else $error("E1 multiframe event missed.");

  property p_ovr;
    @(posedge core_clk) disable iff (sys_rst)
      evt.ovrAbandon |=> st.ls5[`RLS_B5_OVR];
  endproperty
  a_ovr: assert property (p_ovr) else $error("Overrun flag not latched.");

  property p_pe_clear;
    @(posedge core_clk) disable iff (sys_rst)
      (hit(bus, `RLS_OFF_LS5, 1'b1) && !evt.pktEnd) |=> !st.ls5[`RLS_B5_PE];
  endproperty
  a_pe_clear: assert property (p_pe_clear) else $error("Packet end not cleared.");

  property p_hwm;
    @(posedge core_clk) disable iff (sys_rst)
      (evt.fifoLevel > st.watermark && !st.prevAbove) |=> st.ls5[`RLS_B5_HWM];
  endproperty
  a_hwm: assert property (p_hwm) else $error("Watermark edge missed.");

  property p_rai_gate;
    @(posedge core_clk) disable iff (sys_rst)
      (!(evt.esfMode && evt.raiCond) && !st.ls7t[`RLS_B7_RAI]) |=> !st.ls7t[`RLS_B7_RAI];
  endproperty
  a_rai_gate: assert property (p_rai_gate) else $error("RAI-CI set outside alarm.");

  property p_sig_hold;
    @(posedge core_clk) disable iff (sys_rst)
      (st.sigSticky[0] && !hit(bus, `RLS_OFF_SS1, 1'b1)) |=> st.sigSticky[0];
  endproperty
  a_sig_hold: assert property (p_sig_hold) else $error("Signaling bit lost.");

  property p_irq;
    @(posedge core_clk) disable iff (sys_rst)
      (st.ls4[`RLS_B4_SCOS] && st.im4[`RLS_B4_SCOS]) |=> !interruptOut_n;
  endproperty
  a_irq: assert property (p_irq) else $error("Interrupt not raised.");

  property p_restart;
    @(posedge core_clk) disable iff (sys_rst)
      hit(bus, `RLS_OFF_SCD1, 1'b0) |=> spareRestart;
  endproperty
  a_restart: assert property (p_restart) else $error("Spare restart wrong.");

  property p_sum_mask;
    @(posedge core_clk) disable iff (sys_rst)
      (st.im5 == 8'h00) |=> !st.summary[`RLS_BS_LS5];
  endproperty
  a_sum_mask: assert property (p_sum_mask) else $error("Masked bit in summary.");

  property p_mf_free;
    @(posedge core_clk) disable iff (sys_rst)
      (evt.e1Mode && !evt.casEnabled && mfFreeEnd) |=> st.ls4[`RLS_B4_MF];
  endproperty
  a_mf_free: assert property (p_mf_free) else $error("Free multiframe missed.");

  property p_mf_range;
    @(posedge core_clk) disable iff (sys_rst)
      32'(st.mfCnt) < MF_FREE_CYCLES;
  endproperty
  a_mf_range: assert property (p_mf_range) else $error("Multiframe count overrun.");

  property p_obt;
    @(posedge core_clk) disable iff (sys_rst)
      evt.openingByteNext |=> st.ls5[`RLS_B5_OBT];
  endproperty
  a_obt: assert property (p_obt) else $error("Opening byte missed.");

  property p_ps;
    @(posedge core_clk) disable iff (sys_rst)
      evt.pktStart |=> st.ls5[`RLS_B5_PS];
  endproperty
  a_ps: assert property (p_ps) else $error("Packet start missed.");

  // Hold checks look one cycle ahead only; a longer hold follows step by step.
  property p_ne_edge;
    @(posedge core_clk) disable iff (sys_rst)
      (st.prevNonEmpty && !st.ls5[`RLS_B5_NE]) |=> !st.ls5[`RLS_B5_NE];
  endproperty
  a_ne_edge: assert property (p_ne_edge) else $error("Not-empty without edge.");

  property p_hwm_only;
    @(posedge core_clk) disable iff (sys_rst)
      (st.prevAbove && !st.ls5[`RLS_B5_HWM]) |=> !st.ls5[`RLS_B5_HWM];
  endproperty
  a_hwm_only: assert property (p_hwm_only) else $error("Watermark without edge.");

  property p_ais_gate;
    @(posedge core_clk) disable iff (sys_rst)
      (!evt.aisCond && !st.ls7t[`RLS_B7_AIS]) |=> !st.ls7t[`RLS_B7_AIS];
  endproperty
  a_ais_gate: assert property (p_ais_gate) else $error("AIS-CI outside AIS.");

  property p_slc;
    @(posedge core_clk) disable iff (sys_rst)
      (!evt.e1Mode && evt.slcAlign && evt.slcReady) |=> st.ls7t[`RLS_B7_SLC];
  endproperty
  a_slc: assert property (p_slc) else $error("SLC-96 flag missed.");

  property p_fdl;
    @(posedge core_clk) disable iff (sys_rst)
      (!evt.e1Mode && evt.fdlFull) |=> st.ls7t[`RLS_B7_FDL];
  endproperty
  a_fdl: assert property (p_fdl) else $error("FDL full missed.");

  property p_boc;
    @(posedge core_clk) disable iff (sys_rst)
      (!evt.e1Mode && evt.bocDetect) |=> st.ls7t[`RLS_B7_BD];
  endproperty
  a_boc: assert property (p_boc) else $error("BOC detect missed.");

  property p_sa6;
    @(posedge core_clk) disable iff (sys_rst)
      (evt.e1Mode && evt.sa6Codeword) |=> st.ls7e[`RLS_B7_SA6];
  endproperty
  a_sa6: assert property (p_sa6) else $error("Sa6 codeword missed.");

  property p_sax_gate;
    @(posedge core_clk) disable iff (sys_rst)
      (!st.ls7e[`RLS_B7_SAX] && ((evt.saBits ^ st.saPrev) & st.saMask) == 5'h00)
      |=> !st.ls7e[`RLS_B7_SAX];
  endproperty
  a_sax_gate: assert property (p_sax_gate) else $error("Sa change without change.");

  property p_sig_e1only;
    @(posedge core_clk) disable iff (sys_rst)
      (!evt.e1Mode && st.sigSticky[31:24] == 8'h00) |=> st.sigSticky[31:24] == 8'h00;
  endproperty
  a_sig_e1only: assert property (p_sig_e1only) else $error("Channel 25-32 in T1.");

  property p_scos_gate;
    @(posedge core_clk) disable iff (sys_rst)
      (!st.ls4[`RLS_B4_SCOS] && (evt.sigChange & st.sigEnable) == 32'h0000_0000)
      |=> !st.ls4[`RLS_B4_SCOS];
  endproperty
  a_scos_gate: assert property (p_scos_gate) else $error("Disabled channel flagged.");

  property p_spare_short;
    @(posedge core_clk) disable iff (sys_rst)
      (evt.spareLen < 5'h08) |=> spareMasked[7:0] == 8'h00;
  endproperty
  a_spare_short: assert property (p_spare_short) else $error("Short code leaks.");

  property p_sum_rsvd;
    @(posedge core_clk) disable iff (sys_rst)
      (st.summary & 8'ha6) == 8'h00;
  endproperty
  a_sum_rsvd: assert property (p_sum_rsvd) else $error("Unused summary bit set.");

  property p_mask_block;
    @(posedge core_clk) disable iff (sys_rst)
      (st.im4 == 8'h00 && st.im5 == 8'h00 && st.im7 == 8'h00
        && (evt.latchedStatusOne & st.im1) == 8'h00) |=> interruptOut_n;
  endproperty
  a_mask_block: assert property (p_mask_block) else $error("Masked interrupt.");

  property p_ps_hold;
    @(posedge core_clk) disable iff (sys_rst)
      (st.ls5[`RLS_B5_PS] && !hit(bus, `RLS_OFF_LS5, 1'b1)) |=> st.ls5[`RLS_B5_PS];
  endproperty
  a_ps_hold: assert property (p_ps_hold) else $error("Packet start lost.");

  property p_restart_q;
    @(posedge core_clk) disable iff (sys_rst)
      !hit(bus, `RLS_OFF_SCD1, 1'b0) |=> !spareRestart;
  endproperty
  a_restart_q: assert property (p_restart_q) else $error("Stray spare restart.");

endmodule // rls_rx_status
